// ==== rtl/adc_channel_trim_and_input_config_regs.sv ====
`timescale 1ns/1ps
`include "adc_trim_map.svh"
// Summary of operation
// R1 - gain trim upper nibble, resets to 8
// R2 - trim code is 0.1 dB steps, -0.8 base
// R3 - phase trim N delays N modulator cycles
// R4 - phase trim resets zero, zero adds nothing
// R5 - bit 7 picks microphone or line input
// R6 - bits 6-5 pick differential or single-ended
// R7 - bit 4 coupling, resets to DC
// R8 - bit 3 picks low or high swing
// R9 - host retunes gain for high swing
// R10 - bits 2-1 pick high SNR or CMRR
// R11 - bit 0 enables AGC, off at reset
// R12 - host enables AGC only when AC-coupled
// R13 - gain trim at 0x44, reset 0x80
// R14 - phase trim at 0x45, reset zero
// R15 - input setup at 0x46, reset 0x10
// R16 - channel gain at 0x47, reset zero
// R17 - gain code bits 7-2, 0 to 42 dB
// R18 - reserved bits read zero, writes ignored; bit 1 at 0x47 is stored and reads back
module adc_channel_trim_and_input_config_regs (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // control port access, page and address
  input  wire logic [7:0]  i_page,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_wr_en,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_rd_en,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  output logic             o_hit,
  // channel 2 modulator stream
  input  wire logic        i_mod_tick,
  input  wire logic        i_chan2_bit,
  output logic             o_chan2_bit_delayed,
  // channel 2 trim outputs
  output logic [3:0]       o_chan2_gain_trim_code,
  output logic signed [4:0] o_chan2_gain_trim_tenth_db,
  output logic [7:0]       o_chan2_phase_delay_code,
  // channel 3 input setup and gain outputs
  output logic             o_chan3_input_kind,
  output adc_trim_pkg::source_cfg_t o_chan3_source_config,
  output logic             o_chan3_coupling_select,
  output logic             o_chan3_swing_range,
  output adc_trim_pkg::amp_mode_t o_chan3_amp_perf_mode,
  output logic             o_chan3_auto_gain_enable,
  output logic [5:0]       o_chan3_gain_code,
  output logic             o_chan3_gain_db_valid
);
  //////////////////////////////////////////////////////////////////////////////
  // address decode, used for both read and write
  function automatic logic [2:0] decode(input logic [7:0] page, input logic [7:0] addr);
    logic [2:0] r;
    r = 3'h0;
    if (page == `PAGE_ZERO) begin
      case (addr)
        `ADDR_GAIN_TRIM:    r = 3'h4;
        `ADDR_PHASE_TRIM:   r = 3'h5;
        `ADDR_INPUT_SETUP:  r = 3'h6;
        `ADDR_GAIN_SETTING: r = 3'h7;
        default:            r = 3'h0;
      endcase
    end
    return r;
  endfunction : decode

  logic [2:0] dec;
  logic [7:0] regs [`NUM_REGS];
  reg_access_if acc ();

  assign dec         = decode(i_page, i_addr);
  assign o_hit       = dec[2];
  assign acc.index   = dec[1:0];
  assign acc.wr_en   = i_wr_en && dec[2];
  assign acc.wr_data = i_wr_data;

  trim_reg_store u_store (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .acc     (acc),
    .o_regs  (regs)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read answer one cycle after i_rd_en; unmapped reads give zero
  logic hit_q;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      hit_q      <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      hit_q      <= i_rd_en && dec[2];
    end
  end
  assign o_rd_data = hit_q ? acc.rd_data : 8'h00; // [R18]

  //////////////////////////////////////////////////////////////////////////////
  // field extraction
  logic [3:0] trim_code;
  assign trim_code = regs[0][`POS_TRIM_CODE +: 4];
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_chan2_gain_trim_code     <= `TRIM_ZERO_DB_CODE;
      o_chan2_gain_trim_tenth_db <= 5'sh00;
    end else begin
      o_chan2_gain_trim_code     <= trim_code; // [R1]
      // code minus eight gives tenths of a dB
      o_chan2_gain_trim_tenth_db <= $signed({1'b0, trim_code}) - 5'sh08; // [R2]
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_chan2_phase_delay_code <= 8'h00;
    end else begin
      o_chan2_phase_delay_code <= regs[1]; // [R3] [R4]
    end
  end

  phase_delay_line u_delay (
    .i_clock    (i_clock),
    .i_reset    (i_reset),
    .i_mod_tick (i_mod_tick),
    .i_bit      (i_chan2_bit),
    .i_delay    (regs[1]),
    .o_bit      (o_chan2_bit_delayed)
  );

  // outputs follow the register one cycle late; codes pass as stored
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_chan3_input_kind       <= 1'b0;
      o_chan3_source_config    <= adc_trim_pkg::SRC_DIFFERENTIAL;
      o_chan3_coupling_select  <= 1'b1;
      o_chan3_swing_range      <= 1'b0;
      o_chan3_amp_perf_mode    <= adc_trim_pkg::AMP_HIGH_SNR;
      o_chan3_auto_gain_enable <= 1'b0;
    end else begin
      o_chan3_input_kind       <= regs[2][`POS_INPUT_KIND]; // [R5]
      o_chan3_source_config    <= adc_trim_pkg::source_cfg_t'(regs[2][`POS_SOURCE_CFG +: 2]); // [R6]
      o_chan3_coupling_select  <= regs[2][`POS_COUPLING]; // [R7]
      // high swing needs host gain retune, not enforced here
      o_chan3_swing_range      <= regs[2][`POS_SWING]; // [R8]
      o_chan3_amp_perf_mode    <= adc_trim_pkg::amp_mode_t'(regs[2][`POS_AMP_MODE +: 2]); // [R10]
      // consumer applies auto_gain_config_reg; AC coupling is on the host
      o_chan3_auto_gain_enable <= regs[2][`POS_AGC_EN]; // [R11]
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_chan3_gain_code     <= 6'h00;
      o_chan3_gain_db_valid <= 1'b1;
    end else begin
      o_chan3_gain_code     <= regs[3][`POS_GAIN_CODE +: 6]; // [R17]
      // reserved codes 43..63 are stored but flagged
      o_chan3_gain_db_valid <= (regs[3][`POS_GAIN_CODE +: 6] <= `GAIN_CODE_MAX); // [R17]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_trim_lownib_zero: assert property (@(posedge i_clock) disable iff (i_reset)
    regs[0][3:0] == 4'h0) else $error("gain trim low nibble not zero"); // [R18]

  a_trim_write_upper: assert property (@(posedge i_clock) disable iff (i_reset)
    i_wr_en && i_page == 8'h00 && i_addr == 8'h44 |=> regs[0] == ($past(i_wr_data) & 8'hF0))
    else $error("gain trim write not stored"); // [R1]

  a_trim_db_map: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 o_chan2_gain_trim_tenth_db == $signed({1'b0, $past(trim_code)}) - 5'sh08)
    else $error("trim dB mapping wrong"); // [R2]

  a_phase_write: assert property (@(posedge i_clock) disable iff (i_reset)
    i_wr_en && i_page == 8'h00 && i_addr == 8'h45 |=> ##1 o_chan2_phase_delay_code == $past(i_wr_data, 2))
    else $error("phase trim not applied"); // [R3]

  a_phase_zero_pass: assert property (@(posedge i_clock) disable iff (i_reset)
    regs[1] == 8'h00 |=> o_chan2_bit_delayed == $past(i_chan2_bit))
    else $error("zero phase trim delays"); // [R4]

  a_setup_write: assert property (@(posedge i_clock) disable iff (i_reset)
    i_wr_en && i_page == 8'h00 && i_addr == 8'h46 |=> ##1
    {o_chan3_input_kind, o_chan3_coupling_select, o_chan3_swing_range,
     o_chan3_auto_gain_enable} == {$past(i_wr_data[7], 2), $past(i_wr_data[4], 2),
     $past(i_wr_data[3], 2), $past(i_wr_data[0], 2)})
    else $error("input setup fields wrong"); // [R5] [R7] [R8] [R11]

  a_setup_codes: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 o_chan3_source_config == $past(regs[2][6:5]) &&
    o_chan3_amp_perf_mode == $past(regs[2][2:1]))
    else $error("source or amp mode wrong"); // [R6] [R10]

  a_gain_lowbits: assert property (@(posedge i_clock) disable iff (i_reset)
    regs[3][0] == 1'b0) else $error("gain reserved bit set"); // [R18]

  a_gain_valid: assert property (@(posedge i_clock) disable iff (i_reset)
    ##1 o_chan3_gain_db_valid == ($past(regs[3][7:2]) <= 6'h2A))
    else $error("gain code range flag wrong"); // [R17]

  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_reset)
    i_rd_en && !o_hit |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("unmapped read not zero"); // [R18]

  a_read_back: assert property (@(posedge i_clock) disable iff (i_reset)
    i_rd_en && i_page == 8'h00 && i_addr == 8'h46 && !i_wr_en |=>
    o_rd_data == $past(regs[2])) else $error("input setup readback wrong"); // [R15]
endmodule : adc_channel_trim_and_input_config_regs

// ==== rtl/adc_trim_map.svh ====
`ifndef ADC_TRIM_MAP_SVH
`define ADC_TRIM_MAP_SVH
// page and register addresses
`define PAGE_ZERO            8'h00
`define ADDR_GAIN_TRIM       8'h44
`define ADDR_PHASE_TRIM      8'h45
`define ADDR_INPUT_SETUP     8'h46
`define ADDR_GAIN_SETTING    8'h47
// reset values
`define RST_GAIN_TRIM        8'h80
`define RST_PHASE_TRIM       8'h00
`define RST_INPUT_SETUP      8'h10
`define RST_GAIN_SETTING     8'h00
// writable bit masks, reserved bits read zero except gain setting bit 1, which is stored
`define MASK_GAIN_TRIM       8'hF0
`define MASK_PHASE_TRIM      8'hFF
`define MASK_INPUT_SETUP     8'hFF
`define MASK_GAIN_SETTING    8'hFE
// field positions
`define POS_TRIM_CODE        4
`define POS_INPUT_KIND       7
`define POS_SOURCE_CFG       5
`define POS_COUPLING         4
`define POS_SWING            3
`define POS_AMP_MODE         1
`define POS_AGC_EN           0
`define POS_GAIN_CODE        2
// field limits
`define GAIN_CODE_MAX        6'h2A
`define TRIM_ZERO_DB_CODE    4'h8
`define NUM_REGS             4
`endif

// ==== rtl/adc_trim_pkg.sv ====
package adc_trim_pkg;
  typedef enum logic [1:0] {
    SRC_DIFFERENTIAL = 2'h0,
    SRC_SINGLE_ENDED = 2'h1
  } source_cfg_t;
  typedef enum logic [1:0] {
    AMP_HIGH_SNR  = 2'h0,
    AMP_HIGH_CMRR = 2'h2
  } amp_mode_t;
  typedef logic [7:0] reg_byte_t;
endpackage : adc_trim_pkg

// ==== rtl/reg_access_if.sv ====
`timescale 1ns/1ps
interface reg_access_if;
  logic [1:0] index;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport master (output index, output wr_en, output wr_data, input rd_data);
  modport slave  (input index, input wr_en, input wr_data, output rd_data);
endinterface : reg_access_if

// ==== rtl/trim_reg_store.sv ====
`timescale 1ns/1ps
`include "adc_trim_map.svh"
module trim_reg_store (
  // clock and reset
  input  wire logic   i_clock,
  input  wire logic   i_reset,
  // access
  reg_access_if.slave acc,
  // live contents
  output logic [7:0]  o_regs [`NUM_REGS]
);
  //////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RST_V [`NUM_REGS] =
    '{`RST_GAIN_TRIM, `RST_PHASE_TRIM, `RST_INPUT_SETUP, `RST_GAIN_SETTING};
  localparam logic [7:0] MASK_V [`NUM_REGS] =
    '{`MASK_GAIN_TRIM, `MASK_PHASE_TRIM, `MASK_INPUT_SETUP, `MASK_GAIN_SETTING};
  logic [7:0] rd_q;
  genvar g;
  generate
    for (g = 0; g < `NUM_REGS; g++) begin : g_reg
      logic [7:0] val_q;
      always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
          val_q <= RST_V[g]; // [R13] [R14] [R15] [R16]
        end else if (acc.wr_en && acc.index == 2'(g)) begin
          val_q <= acc.wr_data & MASK_V[g]; // [R18]
        end
      end
      assign o_regs[g] = val_q;
    end
  endgenerate
  // read data registered, one cycle after the index
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= o_regs[acc.index];
    end
  end
  assign acc.rd_data = rd_q;
endmodule : trim_reg_store

// ==== rtl/phase_delay_line.sv ====
`timescale 1ns/1ps
module phase_delay_line (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  // modulator stream
  input  wire logic        i_mod_tick,
  input  wire logic        i_bit,
  input  wire logic [7:0]  i_delay,
  output logic             o_bit
);
  //////////////////////////////////////////////////////////////////////////////
  // 256-deep shift line; tap N gives N modulator cycles of delay
  logic [255:0] line_q;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      line_q <= '0;
    end else if (i_mod_tick) begin
      line_q <= {line_q[254:0], i_bit};
    end
  end
  // tap 0 is the live input, so zero adds no delay
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_bit <= 1'b0;
    end else begin
      o_bit <= (i_delay == 8'h00) ? i_bit : line_q[i_delay - 8'h01]; // [R3] [R4]
    end
  end
endmodule : phase_delay_line

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       i_clock,
  // register bus toward the device
  output logic [7:0]      o_page,
  output logic [7:0]      o_addr,
  output logic            o_wr_en,
  output logic [7:0]      o_wr_data,
  output logic            o_rd_en,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  input  wire logic       i_hit
);
  initial begin
    o_page = 8'h00;
    o_addr = 8'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // wr and rd drive the bus as given; nothing checks agc against coupling or high swing against gain
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] dt);
    @(posedge i_clock);
    #1;
    o_page = pg;
    o_addr = ad;
    o_wr_data = dt;
    o_wr_en = 1'b1;
    @(posedge i_clock);
    #1;
    o_wr_en = 1'b0;
    // released data toggles so a stale value never looks valid
    o_wr_data = ~dt;
  endtask : wr
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad,
                    output logic [7:0] dt, output logic ht);
    @(posedge i_clock);
    #1;
    o_page = pg;
    o_addr = ad;
    o_rd_en = 1'b1;
    #1;
    ht = i_hit;
    @(posedge i_clock);
    #1;
    o_rd_en = 1'b0;
    if (i_rd_valid !== 1'b1) begin
      @(posedge i_clock);
      #1;
    end
    dt = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
    o_addr = ~ad;
  endtask : rd
endmodule : host_model

// ==== tb/test_adc_channel_trim_and_input_config_regs.sv ====
`timescale 1ns/1ps
module test_adc_channel_trim_and_input_config_regs;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b0, sbit = 1'b0;
  logic [7:0] page, addr, wdata, rdata, rd;
  logic wen, ren, rvalid, hit, ht;
  int bad_count = 0, checks = 0;
  always #5 clk = ~clk;
  adc_channel_trim_and_input_config_regs dut (
    .i_clock(clk), .i_reset(rst), .i_page(page), .i_addr(addr), .i_wr_en(wen),
    .i_wr_data(wdata), .i_rd_en(ren), .o_rd_data(rdata), .o_rd_valid(rvalid),
    .o_hit(hit), .i_mod_tick(tick), .i_chan2_bit(sbit), .o_chan2_bit_delayed(),
    .o_chan2_gain_trim_code(), .o_chan2_gain_trim_tenth_db(),
    .o_chan2_phase_delay_code(), .o_chan3_input_kind(), .o_chan3_source_config(),
    .o_chan3_coupling_select(), .o_chan3_swing_range(), .o_chan3_amp_perf_mode(),
    .o_chan3_auto_gain_enable(), .o_chan3_gain_code(), .o_chan3_gain_db_valid());
  host_model host (
    .i_clock(clk), .o_page(page), .o_addr(addr), .o_wr_en(wen), .o_wr_data(wdata),
    .o_rd_en(ren), .i_rd_data(rdata), .i_rd_valid(rvalid), .i_hit(hit));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] setup_seen();
    return {dut.o_chan3_input_kind, dut.o_chan3_source_config, dut.o_chan3_coupling_select,
            dut.o_chan3_swing_range, dut.o_chan3_amp_perf_mode, dut.o_chan3_auto_gain_enable};
  endfunction : setup_seen
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // single marked bit; output read at each tick edge, as the consumer samples it
  task automatic delay_check(input logic [7:0] n);
    int first;
    first = 300;
    host.wr(8'h00, 8'h45, n);
    settle();
    for (int k = 0; k < n + 3; k++) begin
      tick = 1'b1;
      sbit = (k == 0);
      @(posedge clk);
      #1;
      tick = 1'b0;
      if (first == 300 && dut.o_chan2_bit_delayed === 1'b1) first = k;
      repeat (3) @(posedge clk);
      #1;
    end
    sbit = 1'b0;
    chk("delay ticks", 8'(first), n);
  endtask : delay_check
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] setups [5] = '{8'h90, 8'h30, 8'h48, 8'h04, 8'h01};
  logic [7:0] rst_vals [4] = '{8'h80, 8'h00, 8'h10, 8'h00};
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'h00, 8'(8'h44 + i), rd, ht);
      chk("reset value", rd, rst_vals[i]);
      chk("hit", {7'h0, ht}, 8'h01);
    end
    chk("setup fields", setup_seen(), 8'h10);
    chk("trim code", {dut.o_chan2_gain_trim_code, 4'h0}, 8'h80);
    chk("tenth db", 8'(dut.o_chan2_gain_trim_tenth_db), 8'h00);
    chk("phase code", dut.o_chan2_phase_delay_code, 8'h00);
    chk("gain", {dut.o_chan3_gain_code, 1'b0, dut.o_chan3_gain_db_valid}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      host.wr(8'h00, 8'h44, {4'(i), 4'hF});
      host.rd(8'h00, 8'h44, rd, ht);
      chk("trim readback", rd, {4'(i), 4'h0});
      chk("tenth db", 8'(dut.o_chan2_gain_trim_tenth_db), 8'(i - 8));
      chk("trim code", {dut.o_chan2_gain_trim_code, 4'h0}, {4'(i), 4'h0});
    end
    host.wr(8'h00, 8'h45, 8'hFF);
    host.rd(8'h00, 8'h45, rd, ht);
    chk("phase readback", rd, 8'hFF);
    delay_check(8'd255);
    delay_check(8'd5);
    delay_check(8'd1);
    delay_check(8'd0);
    foreach (setups[i]) begin
      host.wr(8'h00, 8'h46, setups[i]);
      settle();
      chk("setup fields", setup_seen(), setups[i]);
      host.rd(8'h00, 8'h46, rd, ht);
      chk("setup readback", rd, setups[i]);
    end
    host.wr(8'h00, 8'h47, 8'hFF);
    host.rd(8'h00, 8'h47, rd, ht);
    chk("gain readback", rd, 8'hFE);
    chk("gain", {dut.o_chan3_gain_code, 1'b0, dut.o_chan3_gain_db_valid}, 8'hFC);
    host.wr(8'h00, 8'h47, 8'hA8);
    settle();
    chk("gain", {dut.o_chan3_gain_code, 1'b0, dut.o_chan3_gain_db_valid}, 8'hA9);
    // unmapped page write leaves the bank alone; unmapped address reads zero
    host.wr(8'h01, 8'h44, 8'h00);
    host.rd(8'h00, 8'h44, rd, ht);
    chk("trim after page 1", rd, 8'hF0);
    host.rd(8'h00, 8'h48, rd, ht);
    chk("unmapped read", rd, 8'h00);
    chk("unmapped hit", {7'h0, ht}, 8'h00);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    host.rd(8'h00, 8'h46, rd, ht);
    chk("second reset", rd, 8'h10);
    host.rd(8'h00, 8'h44, rd, ht);
    chk("second reset", rd, 8'h80);
    end_sim();
  end
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule : test_adc_channel_trim_and_input_config_regs
